// *** hw/sewe_pkg.sv ***
// Shared constants and types of the serial EEPROM two-wire slave.
package sewe_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] IFACE_OFFSET = 8'h90;
  localparam int unsigned POWER_BIT = 0;
  localparam int unsigned SDA_BIT = 1;
  localparam int unsigned SCL_BIT = 2;
  localparam logic IFACE_POWER_RESET = 1'h0;
  localparam logic IFACE_SDA_RESET = 1'h1;
  localparam logic IFACE_SCL_RESET = 1'h1;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************************************
  // Array and protocol layout
  // ****************************************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned MEM_DEPTH = 128;
  localparam int unsigned PAGE_W = 3;
  localparam int unsigned PAGE_SIZE = 8;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_RESET = 4'h0;
  localparam logic [2:0] IDX_LAST = 3'h7;
  localparam logic [7:0] VALID_NONE = 8'h00;
  // Device-type code; the value is arbitrary.
  localparam logic [3:0] DEVICE_CODE = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned LINK_PERIOD_NS = 64;
  localparam int unsigned WRITE_TIME_NS = 4000000;
  localparam int unsigned WRITE_CYCLES = (WRITE_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int unsigned TIMER_W = 24;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic power;
    logic scl;
    logic sda;
  } sewe_lines_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_CTRL  = 5'h02,
    ST_ADDR  = 5'h04,
    ST_WDATA = 5'h08,
    ST_RDATA = 5'h10
  } sewe_state_t;

endpackage

// *** hw/sewe_sync.sv ***
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ns
`default_nettype none
module sewe_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock
  input wire logic clk_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end

endmodule
`default_nettype wire

// *** hw/sewe_mem.sv ***
// Byte array of the EEPROM with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module sewe_mem (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [sewe_pkg::ADDR_W-1:0] waddr_i,
  input wire logic [sewe_pkg::DATA_W-1:0] wdata_i,
  // Read port
  input wire logic [sewe_pkg::ADDR_W-1:0] raddr_i,
  output logic [sewe_pkg::DATA_W-1:0] rdata_o
);

  logic [sewe_pkg::DATA_W-1:0] cells [sewe_pkg::MEM_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      cells[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= cells[raddr_i];
  end

endmodule
`default_nettype wire

// *** hw/sewe_top.sv ***
// Two-wire serial slave of the on-chip data EEPROM with its bit-bang register.
// Operation
// - 128 bytes of byte-addressed storage behind the serial interface.
// - Register bit1 is the data line, bit2 the clock line.
// - Register bit0 switches EEPROM power on or off.
// - Data changes only with clock low; changes with clock high are START/STOP.
// - Data falling while clock high is a START; each command opens with one.
// - Data rising while clock high is a STOP; each operation ends with one.
// - One bit per clock pulse, sampled while clock high.
// - Slave acknowledges each received byte on a ninth pulse.
// - No acknowledge while an internal programming cycle runs.
// - Acknowledge holds data low through the whole high phase.
// - Software skips acknowledge on last read byte; slave then releases data.
// - Control byte is four code bits, three ignored bits, one direction bit.
// - Direction bit one reads, zero writes.
// - Acknowledge control byte only on code match and no programming cycle.
// - Byte write acknowledges control, address and one data byte.
// - STOP after a write starts the timed write cycle; no acknowledges meanwhile.
// - Up to eight page bytes are buffered and committed after STOP.
// - Each page byte advances only the three low address bits.
// - More than eight page bytes wrap and overwrite earlier buffered bytes.
// - Address counter holds last accessed location plus one, wrapping within the page after a write.
// - Read continues while software acknowledges; no acknowledge then STOP ends it.
`timescale 1ns/1ns
`default_nettype none
module sewe_top #(
  parameter logic [3:0] DEVICE_CODE = sewe_pkg::DEVICE_CODE,
  parameter int unsigned WRITE_CYCLES = sewe_pkg::WRITE_CYCLES
) (
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link clock
  input wire logic clk_link_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Line observation
  output logic scl_o,
  output logic sda_o,
  output logic busy_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic iface_power;
  logic iface_sda;
  logic iface_scl;
  logic pull_sys;
  logic busy_sys;
  sewe_pkg::sewe_lines_t lines_sys;
  sewe_pkg::sewe_lines_t lines_l;
  logic link_rst;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  sewe_pkg::sewe_state_t state;
  logic [3:0] bit_cnt;
  logic ack_phase;
  logic [7:0] shift;
  logic [7:0] tx;
  logic sda_pull;
  logic master_ack;
  logic byte_done;
  logic ack_end;
  logic ack_ok;
  logic mid_byte;
  logic [sewe_pkg::ADDR_W-1:0] addr_ctr;
  logic [7:0] page [sewe_pkg::PAGE_SIZE];
  logic [7:0] page_valid;
  logic [3:0] page_hi;
  logic commit_go;
  logic busy;
  logic copying;
  logic [2:0] copy_idx;
  logic [sewe_pkg::TIMER_W-1:0] timer;
  logic commit_done;
  logic mem_we;
  logic [7:0] mem_rdata;

  // ****************************************************************
  // Interface register on the system clock
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      iface_power <= sewe_pkg::IFACE_POWER_RESET;
      iface_sda <= sewe_pkg::IFACE_SDA_RESET;
      iface_scl <= sewe_pkg::IFACE_SCL_RESET;
    end else if (reg_wr_i && reg_addr_i == sewe_pkg::IFACE_OFFSET) begin
      iface_power <= reg_wdata_i[sewe_pkg::POWER_BIT];
      iface_sda <= reg_wdata_i[sewe_pkg::SDA_BIT];
      iface_scl <= reg_wdata_i[sewe_pkg::SCL_BIT];
    end
  end

  // Read data show the wired line levels, so software sees the acknowledge.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= sewe_pkg::READ_ZERO;
    end else if (reg_rd_i && reg_addr_i == sewe_pkg::IFACE_OFFSET) begin
      reg_rdata_o <= sewe_pkg::READ_ZERO;
      reg_rdata_o[sewe_pkg::POWER_BIT] <= iface_power;
      reg_rdata_o[sewe_pkg::SDA_BIT] <= iface_sda & ~pull_sys;
      reg_rdata_o[sewe_pkg::SCL_BIT] <= iface_scl;
    end else if (reg_rd_i) begin
      reg_rdata_o <= sewe_pkg::READ_ZERO;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scl_o <= sewe_pkg::IFACE_SCL_RESET;
      sda_o <= sewe_pkg::IFACE_SDA_RESET;
      busy_o <= 1'b0;
    end else begin
      scl_o <= iface_scl;
      sda_o <= iface_sda & ~pull_sys;
      busy_o <= busy_sys;
    end
  end

  // ****************************************************************
  // Domain crossings
  // ****************************************************************
  always_comb begin
    lines_sys.power = iface_power;
    lines_sys.scl = iface_scl;
    lines_sys.sda = iface_sda;
  end

  sewe_sync #(.WIDTH($bits(sewe_pkg::sewe_lines_t))) u_sync_lines (
    .clk_i(clk_link_i),
    .d_i(lines_sys),
    .q_o(lines_l)
  );

  sewe_sync #(.WIDTH(1)) u_sync_rst (
    .clk_i(clk_link_i),
    .d_i(rst_i),
    .q_o(link_rst)
  );

  sewe_sync #(.WIDTH(2)) u_sync_back (
    .clk_i(clk_sys_i),
    .d_i({sda_pull, busy}),
    .q_o({pull_sys, busy_sys})
  );

  // ****************************************************************
  // Line event detection on the link clock
  // ****************************************************************
  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      scl_q <= sewe_pkg::IFACE_SCL_RESET;
      sda_q <= sewe_pkg::IFACE_SDA_RESET;
    end else begin
      scl_q <= lines_l.scl;
      sda_q <= lines_l.sda;
    end
  end

  assign scl_rise = lines_l.scl & ~scl_q;
  assign scl_fall = ~lines_l.scl & scl_q;
  assign start_ev = scl_q & lines_l.scl & sda_q & ~lines_l.sda;
  assign stop_ev = scl_q & lines_l.scl & ~sda_q & lines_l.sda;
  assign byte_done = scl_fall && !ack_phase && bit_cnt == sewe_pkg::BIT_LAST;
  assign ack_end = scl_fall && ack_phase;
  // A clean stop comes after the clock rise of one sampled bit; more bits mean a cut byte.
  assign mid_byte = bit_cnt > 4'h1 || ack_phase;

  // Control byte: four code bits, three ignored, direction last.
  always_comb begin
    ack_ok = 1'b1;
    if (state == sewe_pkg::ST_CTRL) begin
      ack_ok = shift[7:4] == DEVICE_CODE && !busy;
    end else if (busy) begin
      ack_ok = 1'b0;
    end
  end

  // ****************************************************************
  // Slave sequencer
  // ****************************************************************
  always_ff @(posedge clk_link_i) begin
    if (link_rst || !lines_l.power) begin
      state <= sewe_pkg::ST_IDLE;
      bit_cnt <= sewe_pkg::BIT_RESET;
      ack_phase <= 1'b0;
      sda_pull <= 1'b0;
      shift <= sewe_pkg::READ_ZERO;
      tx <= sewe_pkg::READ_ZERO;
      master_ack <= 1'b0;
    end else if (start_ev) begin
      state <= sewe_pkg::ST_CTRL;
      bit_cnt <= sewe_pkg::BIT_RESET;
      ack_phase <= 1'b0;
      sda_pull <= 1'b0;
    end else if (stop_ev) begin
      state <= sewe_pkg::ST_IDLE;
      bit_cnt <= sewe_pkg::BIT_RESET;
      ack_phase <= 1'b0;
      sda_pull <= 1'b0;
    end else begin
      unique case (state)
        sewe_pkg::ST_IDLE: begin
          sda_pull <= 1'b0;
        end
        sewe_pkg::ST_CTRL, sewe_pkg::ST_ADDR, sewe_pkg::ST_WDATA: begin
          if (scl_rise && !ack_phase) begin
            shift <= {shift[6:0], lines_l.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            if (ack_ok) begin
              sda_pull <= 1'b1;
              ack_phase <= 1'b1;
            end else begin
              state <= sewe_pkg::ST_IDLE;
            end
          end else if (ack_end) begin
            ack_phase <= 1'b0;
            bit_cnt <= sewe_pkg::BIT_RESET;
            sda_pull <= 1'b0;
            if (state == sewe_pkg::ST_CTRL && shift[0]) begin
              state <= sewe_pkg::ST_RDATA;
              tx <= mem_rdata;
              sda_pull <= ~mem_rdata[7];
            end else if (state == sewe_pkg::ST_CTRL) begin
              state <= sewe_pkg::ST_ADDR;
            end else begin
              state <= sewe_pkg::ST_WDATA;
            end
          end
        end
        sewe_pkg::ST_RDATA: begin
          if (scl_rise && ack_phase) begin
            master_ack <= ~lines_l.sda;
          end else if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            sda_pull <= 1'b0;
            ack_phase <= 1'b1;
          end else if (scl_fall && !ack_phase) begin
            tx <= {tx[6:0], 1'b0};
            sda_pull <= ~tx[6];
          end else if (ack_end) begin
            ack_phase <= 1'b0;
            bit_cnt <= sewe_pkg::BIT_RESET;
            if (master_ack) begin
              tx <= mem_rdata;
              sda_pull <= ~mem_rdata[7];
            end else begin
              state <= sewe_pkg::ST_IDLE;
              sda_pull <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Address counter
  // ****************************************************************
  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      addr_ctr <= sewe_pkg::ADDR_RESET;
    end else if (lines_l.power && !start_ev && !stop_ev) begin
      if (state == sewe_pkg::ST_ADDR && byte_done) begin
        addr_ctr <= shift[sewe_pkg::ADDR_W-1:0];
      end else if (state == sewe_pkg::ST_WDATA && byte_done) begin
        addr_ctr[sewe_pkg::PAGE_W-1:0] <= addr_ctr[sewe_pkg::PAGE_W-1:0] + 3'h1;
      end else if (state == sewe_pkg::ST_RDATA && scl_rise && ack_phase) begin
        addr_ctr <= addr_ctr + 7'h01;
      end
    end
  end

  // ****************************************************************
  // Page buffer
  // ****************************************************************
  assign commit_go = stop_ev && lines_l.power && state == sewe_pkg::ST_WDATA && !mid_byte
    && page_valid != sewe_pkg::VALID_NONE;

  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      page_valid <= sewe_pkg::VALID_NONE;
      page_hi <= 4'h0;
    end else if (commit_done) begin
      page_valid <= sewe_pkg::VALID_NONE;
    end else if (!busy && (start_ev || (stop_ev && !commit_go) || !lines_l.power)) begin
      page_valid <= sewe_pkg::VALID_NONE;
    end else if (!busy && state == sewe_pkg::ST_WDATA && byte_done) begin
      page_valid[addr_ctr[sewe_pkg::PAGE_W-1:0]] <= 1'b1;
      page_hi <= addr_ctr[sewe_pkg::ADDR_W-1:sewe_pkg::PAGE_W];
    end
  end

  generate
    for (genvar i = 0; i < sewe_pkg::PAGE_SIZE; i++) begin : g_page
      always_ff @(posedge clk_link_i) begin
        if (!busy && state == sewe_pkg::ST_WDATA && byte_done && addr_ctr[sewe_pkg::PAGE_W-1:0] == 3'(i)) begin
          page[i] <= shift;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Internally timed write cycle
  // ****************************************************************
  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      busy <= 1'b0;
      copying <= 1'b0;
      copy_idx <= 3'h0;
      timer <= '0;
    end else if (commit_go && !busy) begin
      busy <= 1'b1;
      copying <= 1'b1;
      copy_idx <= 3'h0;
      timer <= '0;
    end else if (copying) begin
      copy_idx <= copy_idx + 3'h1;
      if (copy_idx == sewe_pkg::IDX_LAST) begin
        copying <= 1'b0;
      end
    end else if (busy) begin
      timer <= timer + 1'b1;
      if (timer == sewe_pkg::TIMER_W'(WRITE_CYCLES - 1)) begin
        busy <= 1'b0;
      end
    end
  end

  assign commit_done = busy && !copying && timer == sewe_pkg::TIMER_W'(WRITE_CYCLES - 1);
  assign mem_we = copying && page_valid[copy_idx];

  sewe_mem u_mem (
    .clk_i(clk_link_i),
    .we_i(mem_we),
    .waddr_i({page_hi, copy_idx}),
    .wdata_i(page[copy_idx]),
    .raddr_i(addr_ctr),
    .rdata_o(mem_rdata)
  );

endmodule
`default_nettype wire

// *** tb/sewe_checker.sv ***
// Concurrent checks on the ports of the serial EEPROM two-wire slave.
`timescale 1ns/1ns
`default_nettype none
module sewe_checker #(
  parameter logic [3:0] DEVICE_CODE = sewe_pkg::DEVICE_CODE,
  parameter int unsigned WRITE_CYCLES = sewe_pkg::WRITE_CYCLES
) (
  // Clocks and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_link_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Line observation
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic busy_o
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic sw_sda;
  logic sw_scl;
  logic pwr;
  logic [23:0] busy_len;
  wire logic wr_if = reg_wr_i && (reg_addr_i == sewe_pkg::IFACE_OFFSET);
  wire logic rd_if = reg_rd_i && (reg_addr_i == sewe_pkg::IFACE_OFFSET);

  // Software levels as last written.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sw_sda <= sewe_pkg::IFACE_SDA_RESET;
      sw_scl <= sewe_pkg::IFACE_SCL_RESET;
      pwr <= sewe_pkg::IFACE_POWER_RESET;
    end else if (wr_if) begin
      sw_sda <= reg_wdata_i[sewe_pkg::SDA_BIT];
      sw_scl <= reg_wdata_i[sewe_pkg::SCL_BIT];
      pwr <= reg_wdata_i[sewe_pkg::POWER_BIT];
    end
  end

  // Length of the current busy period in system cycles.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !busy_o) begin
      busy_len <= 24'h000000;
    end else begin
      busy_len <= busy_len + 24'h000001;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet_high;
    (scl_o && $stable(sw_sda)) [*4];
  endsequence

  sequence s_busy_held;
    busy_o && $past(busy_o, 3) && sw_sda && $past(sw_sda, 4);
  endsequence

  unmapped_zero_a: assert property (reg_rd_i && !rd_if |=> reg_rdata_o == sewe_pkg::READ_ZERO)
    else $error("Unmapped read not zero");
  upper_zero_a: assert property (rd_if |=> reg_rdata_o[7:3] == 5'h00)
    else $error("Unused register bits not zero");
  power_read_a: assert property (rd_if |=> reg_rdata_o[sewe_pkg::POWER_BIT] == pwr)
    else $error("Power bit reads wrong");
  line_read_a: assert property (rd_if |=> reg_rdata_o[2:1] == {scl_o, sda_o})
    else $error("Line bits read wrong");
  scl_follow_a: assert property (wr_if |-> ##[1:3] scl_o == sw_scl)
    else $error("Clock line does not follow register");
  sda_low_a: assert property (wr_if && !reg_wdata_i[sewe_pkg::SDA_BIT] |-> ##[1:3] !sda_o)
    else $error("Data line not low after software drive");
  busy_stop_a: assert property ($rose(busy_o) |-> scl_o && sda_o)
    else $error("Write cycle began without a stop");
  busy_len_a: assert property ($fell(busy_o) |-> (32'(busy_len) >= WRITE_CYCLES * 6)
      && (32'(busy_len) <= (WRITE_CYCLES + 16) * 7))
    else $error("Write cycle length wrong");
  busy_no_ack_a: assert property (s_busy_held |-> sda_o)
    else $error("Data pulled during write cycle");
  ack_stable_a: assert property (s_quiet_high |-> $stable(sda_o))
    else $error("Data changed while clock high");
endmodule

bind sewe_top sewe_checker #(.DEVICE_CODE(DEVICE_CODE), .WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .scl_o(scl_o), .sda_o(sda_o), .busy_o(busy_o)
);
`default_nettype wire

// *** tb/sewe_sw_model.sv ***
// Software model that bit-bangs the serial lines through the interface register.
`timescale 1ns/1ns
`default_nettype none
module sewe_sw_model #(
  parameter int unsigned EDGE_WAIT = 90
) (
  // Clock
  input wire logic clk_sys_i,
  // Register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  // ****************************************************************
  // Register access
  // ****************************************************************
  logic pwr_q = 1'b0;

  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One strobe cycle; idle address and data show the inverse afterwards.
  task automatic reg_access(input logic wr, input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rd);
    @(negedge clk_sys_i);
    reg_wr_o = wr;
    reg_rd_o = !wr;
    reg_addr_o = addr;
    reg_wdata_o = data;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~addr;
    reg_wdata_o = ~data;
    @(negedge clk_sys_i);
    rd = reg_rdata_i;
  endtask

  // ****************************************************************
  // Line control
  // ****************************************************************
  task automatic set_lines(input logic scl, input logic sda);
    logic [7:0] dummy;
    reg_access(1'b1, sewe_pkg::IFACE_OFFSET, {5'h00, scl, sda, pwr_q}, dummy);
    repeat (EDGE_WAIT) @(negedge clk_sys_i);
  endtask

  task automatic start();
    set_lines(1'b0, 1'b1);
    set_lines(1'b1, 1'b1);
    set_lines(1'b1, 1'b0);
    set_lines(1'b0, 1'b0);
  endtask

  task automatic stop();
    set_lines(1'b0, 1'b0);
    set_lines(1'b1, 1'b0);
    set_lines(1'b1, 1'b1);
  endtask

  // Data set while clock low, sampled while clock high.
  task automatic xfer_bit(input logic b, output logic seen);
    logic [7:0] r;
    set_lines(1'b0, b);
    set_lines(1'b1, b);
    reg_access(1'b0, sewe_pkg::IFACE_OFFSET, 8'h00, r);
    seen = r[sewe_pkg::SDA_BIT];
    set_lines(1'b0, b);
  endtask

  task automatic xfer_byte(input logic [7:0] d, input logic ack_bit, output logic [7:0] rx, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], rx[i]);
    end
    xfer_bit(ack_bit, ack_seen);
  endtask
endmodule
`default_nettype wire

// *** tb/sewe_top_bench.sv ***
// Self-checking bench of the serial EEPROM slave through its bit-bang register.
`timescale 1ns/1ns
`default_nettype none
module sewe_top_bench;
  // ****************************************************************
  // Clocks, reset and wiring
  // ****************************************************************
  localparam int unsigned WCYC = 600;
  localparam int unsigned LIMIT = 100000;
  localparam logic [7:0] CW = {sewe_pkg::DEVICE_CODE, 3'h5, 1'b0};
  localparam logic [7:0] CR = {sewe_pkg::DEVICE_CODE, 3'h2, 1'b1};
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic scl;
  logic sda;
  logic busy;
  logic [7:0] rx;
  logic ack;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #7;
    forever #32 clk_link_i = ~clk_link_i;
  end

  sewe_top #(.WRITE_CYCLES(WCYC)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .scl_o(scl), .sda_o(sda),
    .busy_o(busy)
  );
  sewe_sw_model sw_u (
    .clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata)
  );

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic wr_byte(input logic [7:0] d, input logic exp_ack);
    logic [7:0] r;
    logic a;
    sw_u.xfer_byte(d, 1'b1, r, a);
    check("slave ack", {7'h00, a}, {7'h00, exp_ack});
  endtask

  task automatic rd_byte(input logic nack, input logic [7:0] exp);
    logic [7:0] r;
    logic a;
    sw_u.xfer_byte(8'hFF, nack, r, a);
    check("read byte", r, exp);
    check("read ack line", {7'h00, a}, {7'h00, nack});
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (24) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    sw_u.reg_access(1'b1, 8'h91, 8'h00, rx);
    sw_u.reg_access(1'b0, 8'h91, 8'h00, rx);
    check("unmapped read", rx, sewe_pkg::READ_ZERO);
    sw_u.reg_access(1'b0, sewe_pkg::IFACE_OFFSET, 8'h00, rx);
    check("iface reset", rx, 8'h06);
    sw_u.pwr_q = 1'b1;
    sw_u.set_lines(1'b1, 1'b1);
    sw_u.reg_access(1'b0, sewe_pkg::IFACE_OFFSET, 8'h00, rx);
    check("iface power on", rx, 8'h07);
    // Page write of ten bytes from word address 0x8E wraps in page 0x08.
    sw_u.start();
    wr_byte(CW, 1'b0);
    wr_byte(8'h8E, 1'b0);
    for (int i = 0; i < 10; i++) begin
      wr_byte(8'hA0 + 8'(i), 1'b0);
    end
    sw_u.stop();
    check("busy after stop", {7'h00, busy}, 8'h01);
    sw_u.start();
    wr_byte(CW, 1'b1);
    for (int i = 0; i < 8000 && busy !== 1'b0; i++) begin
      @(negedge clk_sys_i);
    end
    check("busy ends", {7'h00, busy}, 8'h00);
    repeat (10) @(negedge clk_sys_i);
    // Poll succeeds, one data byte is buffered, then the next is cut short by a stop.
    sw_u.start();
    wr_byte(CW, 1'b0);
    wr_byte(8'h0D, 1'b0);
    wr_byte(8'h55, 1'b0);
    for (int i = 0; i < 4; i++) begin
      sw_u.xfer_bit(1'b0, ack);
    end
    sw_u.stop();
    check("no write after abort", {7'h00, busy}, 8'h00);
    sw_u.start();
    wr_byte({~sewe_pkg::DEVICE_CODE, 4'h0}, 1'b1);
    // Random read of 0x0C to 0x0E, then a current-address read of 0x0F.
    sw_u.start();
    wr_byte(CW, 1'b0);
    wr_byte(8'h0C, 1'b0);
    sw_u.start();
    wr_byte(CR, 1'b0);
    for (int i = 0; i < 3; i++) begin
      rd_byte(i == 2, 8'hA6 + 8'(i));
    end
    sw_u.stop();
    sw_u.start();
    wr_byte(CR, 1'b0);
    rd_byte(1'b1, 8'hA9);
    sw_u.stop();
    end_sim();
  end
endmodule
`default_nettype wire
